/* rtl/slr_pkg.sv */
// Shared constants and types of the low-power and reset-status unit
`default_nettype none
package slr_pkg;
  // APB address width: word index times four
  localparam int ADDR_W = 18;
  // Register indices; byte address is index times four
  localparam logic [15:0] IDX_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] IDX_RESET_SOURCE = 16'hFE01;
  localparam logic [15:0] IDX_BREAK_FLAG_CTRL = 16'hFE03;
  // Field positions
  localparam int BS_LOWPWR_BIT = 1;
  localparam int BFC_CLEAR_EN_BIT = 7;
  localparam int RS_POR_BIT = 7;
  localparam int RS_PIN_BIT = 6;
  localparam int RS_WDOG_BIT = 5;
  localparam int RS_ILLEGAL_OPCODE_FLAG_BIT = 4;
  localparam int RS_ILLEGAL_FETCH_ADDRESS_FLAG_BIT = 3;
  localparam int RS_MONITOR_BIT = 2;
  localparam int RS_BROWNOUT_BIT = 1;
  // Reset values
  localparam logic [7:0] BS_RESET = 8'h00;
  localparam logic [7:0] BFC_RESET = 8'h00;
  localparam logic [7:0] RS_RESET = 8'h80;
  // Vector byte that marks a blank part
  localparam logic [7:0] BLANK_VECTOR = 8'hFF;
  // Stop recovery, in cycles of the fastest bus clock
  localparam int RECOVERY_LONG_CYC = 4096;
  localparam int RECOVERY_SHORT_CYC = 32;
  localparam int RECOVERY_CNT_W = 13;
  // Low-power state machine
  typedef enum logic [3:0] {
    SLR_RUN = 4'h1,
    SLR_WAIT = 4'h2,
    SLR_STOP = 4'h4,
    SLR_RECOVER = 4'h8
  } slr_state_t;
endpackage : slr_pkg
`default_nettype wire

/* rtl/slr_if.sv */
// Interface between the top and its timer and reset-status modules
`default_nettype none
interface slr_if;
  logic tmr_clear;
  logic tmr_short;
  logic tmr_done;
  logic [7:0] rs_events;
  logic [7:0] rs_clear_mask;
  logic [7:0] rs_flags;
  modport top (output tmr_clear, tmr_short, rs_events, rs_clear_mask,
               input tmr_done, rs_flags);
  modport timer (input tmr_clear, tmr_short, output tmr_done);
  modport status (input rs_events, rs_clear_mask, output rs_flags);
endinterface : slr_if
`default_nettype wire

/* rtl/slr_recovery_timer.sv */
// Stop-recovery counter, held clear outside recovery
`default_nettype none
module slr_recovery_timer #(
  parameter int LONG_CYC = slr_pkg::RECOVERY_LONG_CYC,
  parameter int SHORT_CYC = slr_pkg::RECOVERY_SHORT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control from the top
  slr_if.timer tif
);
  typedef struct packed {
    logic [slr_pkg::RECOVERY_CNT_W-1:0] cnt;
  } slr_tmr_state_t;

  localparam logic [slr_pkg::RECOVERY_CNT_W-1:0] LAST_LONG =
    slr_pkg::RECOVERY_CNT_W'(LONG_CYC - 1);
  localparam logic [slr_pkg::RECOVERY_CNT_W-1:0] LAST_SHORT =
    slr_pkg::RECOVERY_CNT_W'(SHORT_CYC - 1);

  slr_tmr_state_t s_q;
  slr_tmr_state_t s_d;
  logic [slr_pkg::RECOVERY_CNT_W-1:0] last;

  assign last = tif.tmr_short ? LAST_SHORT : LAST_LONG;
  assign tif.tmr_done = ~tif.tmr_clear && (s_q.cnt == last);

  always_comb
  begin
    s_d = s_q;
    if (tif.tmr_clear)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt != last)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule : slr_recovery_timer
`default_nettype wire

/* rtl/slr_reset_status.sv */
// Reset-source flags: set by events, cleared bit by bit on read
`default_nettype none
module slr_reset_status (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Events and read clear from the top
  slr_if.status sif
);
  typedef struct packed {
    logic [7:0] flags;
  } slr_rs_state_t;

  slr_rs_state_t s_q;
  slr_rs_state_t s_d;

  assign sif.rs_flags = s_q.flags;

  always_comb
  begin
    s_d = s_q;
    // Only bits already returned are cleared; a new event wins
    s_d.flags = (s_q.flags & ~sif.rs_clear_mask) | sif.rs_events;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s_q.flags <= slr_pkg::RS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule : slr_reset_status
`default_nettype wire

/* rtl/slr_top.sv */
// Top of the low-power sequencer and reset-status unit
// Contract
// - Break without clear enable protects flags
// - Clear enable lets flags clear in break
// - Two-step clears stay protected across break
// - Wait or stop clears interrupt mask
// - Low-power holds CPU unclocked until wake
// - Wait stops CPU clock, peripherals run
// - Wait interrupt wakes, stacking next cycle
// - Reset or emulation break ends wait
// - Watchdog runs in wait unless disabled
// - Stop clears counter, stops all clocks
// - Stop ends on interrupt, reset, break
// - Recovery 4096 cycles, or 32 short
// - Counter held clear until recovery starts
// - Three registers at their indices
// - Reset status read clears its flags
// - Power-on sets only its flag
// - Several reset flags may coexist
// - Separate flags for each reset source
// - Blank vectors without test voltage flag
// - Clear enable bit readable and writable
//
// Our own choice: the APB slave port.
`default_nettype none
module slr_top #(
  parameter int LONG_CYC = slr_pkg::RECOVERY_LONG_CYC,
  parameter int SHORT_CYC = slr_pkg::RECOVERY_SHORT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU core
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic module_irq,
  input wire logic break_req,
  input wire logic break_active,
  input wire logic emulation_mode,
  output logic cpu_clock_en,
  output logic periph_clock_en,
  output logic imask_clear,
  output logic stack_start,
  // Peripheral flag protection
  output logic flag_clear_allow,
  // Configuration bits
  input wire logic short_recovery_select,
  input wire logic watchdog_disable_bit,
  output logic watchdog_enable,
  // Reset sources
  input wire logic rst_pin_evt,
  input wire logic rst_watchdog_evt,
  input wire logic rst_illegal_opcode_evt,
  input wire logic rst_illegal_fetch_evt,
  input wire logic rst_brownout_evt,
  input wire logic [7:0] reset_vector_hi,
  input wire logic [7:0] reset_vector_lo,
  input wire logic irq_at_test_voltage
);
  typedef struct packed {
    slr_pkg::slr_state_t st;
    logic clr_en;
    logic lp_flag;
    logic por_chk;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic cpu_ck;
    logic per_ck;
    logic imask_clr;
    logic stack;
    logic wdog_en;
    logic clr_allow;
  } slr_top_state_t;

  localparam slr_top_state_t TOP_RESET = '{
    st: slr_pkg::SLR_RUN,
    clr_en: slr_pkg::BFC_RESET[slr_pkg::BFC_CLEAR_EN_BIT],
    lp_flag: slr_pkg::BS_RESET[slr_pkg::BS_LOWPWR_BIT],
    por_chk: 1'b1,
    cpu_ck: 1'b1,
    per_ck: 1'b1,
    clr_allow: 1'b1,
    default: '0
  };

  localparam logic [slr_pkg::ADDR_W-1:0] ADDR_BS =
    {slr_pkg::IDX_BREAK_STATUS, 2'b00};
  localparam logic [slr_pkg::ADDR_W-1:0] ADDR_RS =
    {slr_pkg::IDX_RESET_SOURCE, 2'b00};
  localparam logic [slr_pkg::ADDR_W-1:0] ADDR_BFC =
    {slr_pkg::IDX_BREAK_FLAG_CTRL, 2'b00};

  slr_top_state_t s_q;
  slr_top_state_t s_d;
  slr_if tif ();

  logic setup;
  logic done;
  logic any_rst;
  logic [7:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  slr_recovery_timer #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .tif(tif.timer)
  );

  slr_reset_status u_status (
    .clock(clock),
    .reset_n(reset_n),
    .sif(tif.status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Glue

  assign setup = psel && !penable;
  assign done = psel && penable && s_q.rdy;
  assign any_rst = rst_pin_evt || rst_watchdog_evt || rst_illegal_opcode_evt
                   || rst_illegal_fetch_evt || rst_brownout_evt;

  always_comb
  begin
    events = '0;
    events[slr_pkg::RS_PIN_BIT] = rst_pin_evt;
    events[slr_pkg::RS_WDOG_BIT] = rst_watchdog_evt;
    events[slr_pkg::RS_ILLEGAL_OPCODE_FLAG_BIT] = rst_illegal_opcode_evt;
    events[slr_pkg::RS_ILLEGAL_FETCH_ADDRESS_FLAG_BIT] = rst_illegal_fetch_evt;
    events[slr_pkg::RS_BROWNOUT_BIT] = rst_brownout_evt;
    // Checked once, in the first cycle after power-on
    events[slr_pkg::RS_MONITOR_BIT] = s_q.por_chk
      && (reset_vector_hi == slr_pkg::BLANK_VECTOR)
      && (reset_vector_lo == slr_pkg::BLANK_VECTOR)
      && !irq_at_test_voltage;
  end

  assign tif.rs_events = events;
  // Clear exactly the bits handed out, so a late event survives
  assign tif.rs_clear_mask = (done && !pwrite && paddr == ADDR_RS)
                             ? s_q.rdata[7:0] : 8'h00;
  // Counter runs only during recovery
  assign tif.tmr_clear = (s_q.st != slr_pkg::SLR_RECOVER);
  assign tif.tmr_short = short_recovery_select;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    s_d.imask_clr = 1'b0;
    s_d.stack = 1'b0;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    s_d.por_chk = 1'b0;

    // Registers answer in the access cycle straight after setup
    if (setup)
    begin
      s_d.rdy = 1'b1;
      s_d.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_BS:
        begin
          s_d.rdata[slr_pkg::BS_LOWPWR_BIT] = s_q.lp_flag;
        end
        ADDR_RS:
        begin
          s_d.rdata[7:0] = tif.rs_flags;
        end
        ADDR_BFC:
        begin
          s_d.rdata[slr_pkg::BFC_CLEAR_EN_BIT] = s_q.clr_en;
        end
        default:
        begin
          s_d.err = 1'b1;
        end
      endcase
    end
    else if (psel && penable && !s_q.rdy)
    begin
      s_d.rdy = 1'b1;
    end

    if (done && pwrite && pstrb[0] && !s_q.err)
    begin
      case (paddr)
        ADDR_BS:
        begin
          // Writing zero clears; writing one has no effect
          if (!pwdata[slr_pkg::BS_LOWPWR_BIT])
          begin
            s_d.lp_flag = 1'b0;
          end
        end
        ADDR_BFC:
        begin
          s_d.clr_en = pwdata[slr_pkg::BFC_CLEAR_EN_BIT];
        end
        default:
        begin
          s_d.clr_en = s_q.clr_en;
        end
      endcase
    end

    // Low-power sequencing; after the write so a set wins over a clear
    case (s_q.st)
      slr_pkg::SLR_RUN:
      begin
        if (wait_exec)
        begin
          s_d.st = slr_pkg::SLR_WAIT;
          s_d.imask_clr = 1'b1;
        end
        else if (stop_exec)
        begin
          s_d.st = slr_pkg::SLR_STOP;
          s_d.imask_clr = 1'b1;
        end
      end
      slr_pkg::SLR_WAIT:
      begin
        if (any_rst)
        begin
          s_d.st = slr_pkg::SLR_RUN;
        end
        else if (module_irq)
        begin
          s_d.st = slr_pkg::SLR_RUN;
          s_d.stack = 1'b1;
        end
        else if (break_req && emulation_mode)
        begin
          s_d.st = slr_pkg::SLR_RUN;
          s_d.stack = 1'b1;
          s_d.lp_flag = 1'b1;
        end
      end
      slr_pkg::SLR_STOP:
      begin
        if (any_rst)
        begin
          s_d.st = slr_pkg::SLR_RUN;
        end
        else if (module_irq || break_req)
        begin
          s_d.st = slr_pkg::SLR_RECOVER;
          if (break_req)
          begin
            s_d.lp_flag = 1'b1;
          end
        end
      end
      slr_pkg::SLR_RECOVER:
      begin
        if (any_rst)
        begin
          s_d.st = slr_pkg::SLR_RUN;
        end
        else if (tif.tmr_done)
        begin
          // Stacking waits for the full recovery count
          s_d.st = slr_pkg::SLR_RUN;
          s_d.stack = 1'b1;
        end
      end
      default:
      begin
        s_d.st = slr_pkg::SLR_RUN;
      end
    endcase

    s_d.cpu_ck = (s_d.st == slr_pkg::SLR_RUN);
    s_d.per_ck = (s_d.st == slr_pkg::SLR_RUN)
                 || (s_d.st == slr_pkg::SLR_WAIT);
    s_d.wdog_en = !watchdog_disable_bit;
    // Peripherals hold their two-step state; they only need this gate
    s_d.clr_allow = !break_active || s_q.clr_en;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s_q <= TOP_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign cpu_clock_en = s_q.cpu_ck;
  assign periph_clock_en = s_q.per_ck;
  assign imask_clear = s_q.imask_clr;
  assign stack_start = s_q.stack;
  assign watchdog_enable = s_q.wdog_en;
  assign flag_clear_allow = s_q.clr_allow;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_protect;
    (break_active && !s_q.clr_en) |=> !flag_clear_allow;
  endproperty
  a_protect: assert property (p_protect)
    else $error("flag clearing allowed during protected break");

  property p_allow;
    (break_active && s_q.clr_en) |=> flag_clear_allow;
  endproperty
  a_allow: assert property (p_allow)
    else $error("flag clearing blocked although enabled");

  property p_imask;
    (s_q.st == slr_pkg::SLR_RUN && (wait_exec || stop_exec))
      |=> imask_clear && !cpu_clock_en;
  endproperty
  a_imask: assert property (p_imask)
    else $error("low-power entry did not clear mask or stop cpu");

  property p_wait_clocks;
    (s_q.st == slr_pkg::SLR_WAIT) |-> !cpu_clock_en && periph_clock_en;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks)
    else $error("wrong clock gating in wait");

  property p_wait_wake;
    (s_q.st == slr_pkg::SLR_WAIT && module_irq && !any_rst)
      |=> stack_start && cpu_clock_en;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("wait wake did not stack one cycle later");

  property p_wait_break;
    (s_q.st == slr_pkg::SLR_WAIT && break_req && emulation_mode
     && !any_rst && !module_irq) |=> s_q.lp_flag;
  endproperty
  a_wait_break: assert property (p_wait_break)
    else $error("break in wait did not set low-power flag");

  // Reset in the antecedent: the output is forced low through the release edge
  property p_wdog;
    (reset_n && !watchdog_disable_bit) |=> watchdog_enable;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog not enabled");

  property p_stop;
    (s_q.st == slr_pkg::SLR_STOP) |-> !periph_clock_en && !cpu_clock_en
      && tif.tmr_clear;
  endproperty
  a_stop: assert property (p_stop)
    else $error("clocks or counter active in stop");

  property p_short_recovery;
    ($rose(s_q.st == slr_pkg::SLR_RECOVER) && short_recovery_select
     && $stable(short_recovery_select) && !any_rst)
      |-> (s_q.st == slr_pkg::SLR_RECOVER && !stack_start) ##31
          (s_q.st == slr_pkg::SLR_RECOVER) ##1 stack_start;
  endproperty
  a_short_recovery: assert property (p_short_recovery)
    else $error("short recovery did not last 32 cycles");

  property p_read_clear;
    (done && !pwrite && paddr == ADDR_RS && events == 8'h00)
      |=> (tif.rs_flags & $past(s_q.rdata[7:0])) == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("reset status read did not clear flags");

  c_wait_wake: cover property (s_q.st == slr_pkg::SLR_WAIT ##1 stack_start);
  c_stop_done: cover property (s_q.st == slr_pkg::SLR_RECOVER
                               ##1 stack_start);
  c_status_read: cover property (done && !pwrite && paddr == ADDR_RS);
  c_break_prot: cover property (break_active && !flag_clear_allow);
endmodule : slr_top
`default_nettype wire

/* verif/slr_periph_model.sv */
// Peripheral status flag with a two-step clear, guarded by the unit
`default_nettype none
module slr_periph_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Bench commands: bit0 set, bit1 first step, bit2 second step
  input wire logic [2:0] cmd,
  // Protection from the unit
  input wire logic flag_clear_allow,
  // Flag seen by software
  output logic flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic armed_q;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      flag <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      if (cmd[1])
        armed_q <= 1'b1;
      // A refused second step keeps the first one armed
      if (cmd[2] && armed_q && flag_clear_allow)
      begin
        flag <= 1'b0;
        armed_q <= 1'b0;
      end
      if (cmd[0])
        flag <= 1'b1;
    end
  end
endmodule : slr_periph_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the low-power and reset-status unit
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Short long-recovery count keeps the run brief
  localparam int LONG_T = 64;
  localparam int SHORT_T = slr_pkg::RECOVERY_SHORT_CYC;
  localparam logic [17:0] A_BS = {slr_pkg::IDX_BREAK_STATUS, 2'b00};
  localparam logic [17:0] A_RS = {slr_pkg::IDX_RESET_SOURCE, 2'b00};
  localparam logic [17:0] A_BF = {slr_pkg::IDX_BREAK_FLAG_CTRL, 2'b00};
  localparam logic [17:0] A_UN = 18'h3F808;
  localparam logic [7:0] POR = 8'h01 << slr_pkg::RS_POR_BIT;
  localparam logic [7:0] CLR_EN = 8'h01 << slr_pkg::BFC_CLEAR_EN_BIT;
  localparam logic [7:0] LP_FLAG = 8'h01 << slr_pkg::BS_LOWPWR_BIT;
  logic clock = 1'b0, reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [slr_pkg::ADDR_W-1:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_clock_en, periph_clock_en, imask_clear;
  logic stack_start, flag_clear_allow, watchdog_enable, flag;
  logic wait_exec = 1'b0, stop_exec = 1'b0, module_irq = 1'b0;
  logic break_req = 1'b0, break_active = 1'b0, emulation_mode = 1'b0;
  logic short_recovery_select = 1'b0, watchdog_disable_bit = 1'b0;
  logic irq_at_test_voltage = 1'b0;
  logic [7:0] reset_vector_hi = 8'h00, reset_vector_lo = 8'h00;
  // Reset events: 4 pin, 3 watchdog, 2 opcode, 1 fetch, 0 brownout
  logic [4:0] evt = 5'h00;
  logic [2:0] cmd = 3'h0;
  int err_count = 0, tests_run = 0;
  int pos [5] = '{slr_pkg::RS_BROWNOUT_BIT, slr_pkg::RS_ILLEGAL_FETCH_ADDRESS_FLAG_BIT,
    slr_pkg::RS_ILLEGAL_OPCODE_FLAG_BIT, slr_pkg::RS_WDOG_BIT, slr_pkg::RS_PIN_BIT};

  always #4 clock = ~clock;

  slr_top #(.LONG_CYC(LONG_T), .SHORT_CYC(SHORT_T)) u_slr_top (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .module_irq(module_irq),
    .break_req(break_req), .break_active(break_active),
    .emulation_mode(emulation_mode), .cpu_clock_en(cpu_clock_en),
    .periph_clock_en(periph_clock_en), .imask_clear(imask_clear),
    .stack_start(stack_start), .flag_clear_allow(flag_clear_allow),
    .short_recovery_select(short_recovery_select),
    .watchdog_disable_bit(watchdog_disable_bit),
    .watchdog_enable(watchdog_enable), .rst_pin_evt(evt[4]),
    .rst_watchdog_evt(evt[3]), .rst_illegal_opcode_evt(evt[2]),
    .rst_illegal_fetch_evt(evt[1]), .rst_brownout_evt(evt[0]),
    .reset_vector_hi(reset_vector_hi), .reset_vector_lo(reset_vector_lo),
    .irq_at_test_voltage(irq_at_test_voltage)
  );

  slr_periph_model u_slr_periph_model (
    .clock(clock), .reset_n(reset_n), .cmd(cmd),
    .flag_clear_allow(flag_clear_allow), .flag(flag)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] bitv(input int p);
    return 8'h01 << p;
  endfunction : bitv

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic bound_fail();
    err_count++;
    stop_test();
  endtask : bound_fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // Read at the edge itself, before the slave's updates land
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      bound_fail();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [17:0] a, input logic [7:0] e);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 8'h00, 4'h0, rd, er);
    chk(rd, {24'h000000, e});
    chk1(er, 1'b0);
  endtask : rchk

  task automatic wr(input logic [17:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, s, rd, er);
    chk1(er, 1'b0);
  endtask : wr

  task automatic do_reset(input logic [7:0] v, input logic tv);
    @(posedge clock);
    reset_n <= 1'b0;
    reset_vector_hi <= v;
    reset_vector_lo <= v;
    irq_at_test_voltage <= tv;
    cyc(2);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic pulse_evt(input logic [4:0] v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= 5'h00;
  endtask : pulse_evt

  task automatic pulse_cmd(input logic [2:0] v);
    @(posedge clock);
    cmd <= v;
    @(posedge clock);
    cmd <= 3'h0;
    #1;
  endtask : pulse_cmd

  // w: bit1 stop, bit0 wait
  task automatic enter(input logic [1:0] w);
    @(posedge clock);
    {stop_exec, wait_exec} <= w;
    @(posedge clock);
    {stop_exec, wait_exec} <= 2'b00;
    #1;
  endtask : enter

  // w: bit1 break request, bit0 module interrupt
  task automatic kick(input logic [1:0] w);
    @(posedge clock);
    {break_req, module_irq} <= w;
    @(posedge clock);
    {break_req, module_irq} <= 2'b00;
    #1;
  endtask : kick

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] rd;
    logic er;
    int n;
    do_reset(8'h00, 1'b0);
    evt <= 5'h01;
    @(posedge clock);
    evt <= 5'h00;
    rchk(A_RS, POR | bitv(slr_pkg::RS_BROWNOUT_BIT));
    rchk(A_RS, 8'h00);
    rchk(A_BS, 8'h00);
    rchk(A_BF, 8'h00);
    apb(1'b0, A_UN, 8'h00, 4'h0, rd, er);
    chk(rd, 32'h00000000);
    chk1(er, 1'b1);
    $display("Test reset_values done");
    for (int i = 0; i < 5; i++)
    begin
      pulse_evt(5'h01 << i);
      rchk(A_RS, bitv(pos[i]));
    end
    pulse_evt(5'h10);
    pulse_evt(5'h08);
    rchk(A_RS, bitv(pos[4]) | bitv(pos[3]));
    pulse_evt(5'h03);
    rchk(A_RS, bitv(pos[0]) | bitv(pos[1]));
    for (int t = 0; t < 2; t++)
    begin
      do_reset(8'hFF, t[0]);
      cyc(3);
      rchk(A_RS, t ? POR : POR | bitv(slr_pkg::RS_MONITOR_BIT));
    end
    do_reset(8'h00, 1'b0);
    $display("Test reset_sources done");
    wr(A_BF, 8'hFF, 4'hF);
    rchk(A_BF, CLR_EN);
    wr(A_BF, 8'h00, 4'h0);
    rchk(A_BF, CLR_EN);
    wr(A_BF, 8'h00, 4'hF);
    rchk(A_BF, 8'h00);
    $display("Test flag_control done");
    pulse_cmd(3'b001);
    pulse_cmd(3'b010);
    @(posedge clock);
    break_active <= 1'b1;
    cyc(2);
    #1 chk1(flag_clear_allow, 1'b0);
    pulse_cmd(3'b100);
    chk1(flag, 1'b1);
    @(posedge clock);
    break_active <= 1'b0;
    cyc(2);
    pulse_cmd(3'b100);
    chk1(flag, 1'b0);
    wr(A_BF, CLR_EN, 4'hF);
    pulse_cmd(3'b001);
    @(posedge clock);
    break_active <= 1'b1;
    cyc(2);
    #1 chk1(flag_clear_allow, 1'b1);
    pulse_cmd(3'b010);
    pulse_cmd(3'b100);
    @(posedge clock);
    break_active <= 1'b0;
    cyc(2);
    #1 chk1(flag, 1'b0);
    $display("Test break_protection done");
    @(posedge clock);
    watchdog_disable_bit <= 1'b1;
    cyc(2);
    #1 chk1(watchdog_enable, 1'b0);
    @(posedge clock);
    watchdog_disable_bit <= 1'b0;
    enter(2'b01);
    chk1(imask_clear, 1'b1);
    chk1(cpu_clock_en, 1'b0);
    chk1(periph_clock_en, 1'b1);
    kick(2'b10);
    chk1(cpu_clock_en, 1'b0);
    chk1(watchdog_enable, 1'b1);
    kick(2'b01);
    chk1(stack_start, 1'b1);
    chk1(cpu_clock_en, 1'b1);
    @(posedge clock);
    emulation_mode <= 1'b1;
    enter(2'b01);
    kick(2'b10);
    chk1(cpu_clock_en, 1'b1);
    rchk(A_BS, LP_FLAG);
    wr(A_BS, 8'h00, 4'hF);
    rchk(A_BS, 8'h00);
    enter(2'b01);
    do_reset(8'h00, 1'b0);
    @(posedge clock);
    #1 chk1(cpu_clock_en, 1'b1);
    chk1(stack_start, 1'b0);
    $display("Test wait_mode done");
    for (int k = 0; k < 3; k++)
    begin
      // The long case runs the bench's 64-cycle count, not the full 4096 crystal users must keep
      @(posedge clock);
      short_recovery_select <= (k != 1);
      enter(2'b10);
      chk1(imask_clear, 1'b1);
      chk1(periph_clock_en, 1'b0);
      cyc(k * 40);
      kick(k == 2 ? 2'b10 : 2'b01);
      chk1(periph_clock_en, 1'b0);
      n = 0;
      while (stack_start !== 1'b1 && n < 5000)
      begin
        @(posedge clock);
        #1;
        n++;
      end
      if (n >= 5000)
        bound_fail();
      chk(32'(n), 32'((k != 1) ? SHORT_T : LONG_T));
      chk1(periph_clock_en, 1'b1);
    end
    rchk(A_BS, LP_FLAG);
    enter(2'b10);
    pulse_evt(5'h01);
    #1 chk1(cpu_clock_en, 1'b1);
    chk1(stack_start, 1'b0);
    $display("Test stop_mode done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
